//--- flash_program_guard.sv
// flash program guard: key lock, page erase, byte/pair program, page security
// assumes synchronous cpu strobes, an array that returns the addressed pair
// combinationally and an apb master; the cpu honours cpu_stall
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flash_program_guard #(
    parameter int ERASE_CYC = flash_guard_pkg::ERASE_CYCLES,
    parameter int PROG_CYC  = flash_guard_pkg::PROG_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // cpu side
    input  wire logic                      move_wr,
    input  wire flash_guard_pkg::move_wr_t move_wr_req,
    input  wire logic                      move_rd,
    input  wire logic [15:0]               exec_addr,
    input  wire logic                      code_rd,
    input  wire logic [15:0]               code_rd_addr,
    output logic                           external_ram_space_wr,
    output logic                           external_ram_space_rd,
    output logic                           code_rd_ok,
    output logic                           cpu_stall,
    output var  logic                      flash_error_reset,
    // debug port side
    input  wire logic                      dbg_req,
    input  wire flash_guard_pkg::dbg_cmd_t dbg_cmd,
    input  wire logic [15:0]               dbg_addr,
    input  wire logic [7:0]                dbg_wdata,
    output var  logic                      dbg_done,
    output var  logic                      dbg_refused,
    // flash array side
    input  wire logic [7:0]                lock_byte,
    input  wire logic [15:0]               flash_rd_pair,
    output var  logic                      flash_start,
    output var  flash_guard_pkg::flash_cmd_t flash_cmd,
    output logic                           flash_busy
);
    import flash_guard_pkg::*;

    initial begin
        if (PROG_CYC < 1 || ERASE_CYC < 1) begin
            $error("operation cycle counts must be at least one");
        end
    end

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } seq_state_t;

    // page lock test against the lock byte complement
    function automatic logic page_locked(input logic [15:0] a, input logic [7:0] lb);
        logic [7:0] n;
        n = ~lb;
        page_locked = ({1'b0, a[15:9]} < n) || (a[15:9] == LOCK_PAGE && n != 8'h00);
    endfunction : page_locked

    // firmware access permission; exec is where the code runs
    function automatic logic fw_allowed(input logic [15:0] a, input logic [15:0] exec,
                                        input logic [7:0] lb, input logic erase);
        logic on_lock_pg;
        on_lock_pg = (a[15:9] == LOCK_PAGE);
        if (a > LOCK_BYTE_ADDR) begin
            fw_allowed = 1'b0;
        end else if (on_lock_pg) begin
            fw_allowed = !erase && (!page_locked(a, lb) || page_locked(exec, lb));
        end else begin
            fw_allowed = !page_locked(a, lb) || page_locked(exec, lb);
        end
    endfunction : fw_allowed

    logic [1:0]  psc;
    logic        pfe;
    key_state_t  key;
    seq_state_t  seq;
    logic [31:0] cnt;
    logic        pair_pend;
    logic [15:0] pair_addr;
    logic [7:0]  pair_even;

    wire logic swe = psc[SWE_BIT];
    wire logic see = psc[SEE_BIT];
    wire logic apb_wr = psel && penable && pwrite;
    wire logic key_wr = apb_wr && paddr == KEY_OFFSET;
    wire logic mapped = paddr == PSC_OFFSET || paddr == KEY_OFFSET ||
                        paddr == PFE_OFFSET || paddr == STAT_OFFSET;

    // cpu flash write decode
    wire logic fl_wr     = move_wr && swe && seq == SEQ_IDLE;             // [RULE_06] [RULE_09]
    wire logic fl_erase  = fl_wr && see;                                  // [RULE_09]
    wire logic fw_ok     = fw_allowed(move_wr_req.addr, exec_addr, lock_byte, fl_erase);
    wire logic [7:0] old_byte = move_wr_req.addr[0] ? flash_rd_pair[15:8] : flash_rd_pair[7:0];
    wire logic [7:0] new_byte = old_byte & move_wr_req.data;              // [RULE_07]
    // lock byte may only be rewritten with its own value
    wire logic lock_grow = move_wr_req.addr == LOCK_BYTE_ADDR && new_byte != old_byte;
    wire logic fw_fault  = fl_wr && key == KEY_OPEN && (!fw_ok || lock_grow); // [RULE_22]
    wire logic fw_go     = fl_wr && key == KEY_OPEN && !fw_fault;
    wire logic even_hold = fw_go && !fl_erase && pfe && !move_wr_req.addr[0]; // [RULE_11]
    wire logic fw_start  = fw_go && !even_hold;

    // debug port decode
    wire logic dbg_mod   = dbg_cmd != DBG_READ;
    wire logic [7:0] dbg_old = dbg_addr[0] ? flash_rd_pair[15:8] : flash_rd_pair[7:0];
    wire logic dbg_deny  = dbg_cmd != DBG_CHIP &&
                           ((page_locked(dbg_addr, lock_byte) &&
                             !(dbg_cmd == DBG_READ && dbg_addr == LOCK_BYTE_ADDR)) ||  // [RULE_18] [RULE_19]
                            dbg_addr > LOCK_BYTE_ADDR ||
                            (dbg_cmd == DBG_WRITE && dbg_addr == LOCK_BYTE_ADDR &&
                             (dbg_old & dbg_wdata) != dbg_old));                       // [RULE_19]
    wire logic dbg_take  = dbg_req && !move_wr && (seq == SEQ_IDLE || !dbg_mod);
    wire logic dbg_start = dbg_take && !dbg_deny && dbg_mod;
    wire logic op_done   = seq == SEQ_BUSY && cnt == 32'h0000_0001;

    // routing to external ram: reads always, writes unless steered
    assign external_ram_space_rd    = move_rd;                                          // [RULE_15]
    assign external_ram_space_wr    = move_wr && !swe;                                  // [RULE_06]
    assign code_rd_ok = code_rd && (code_rd_addr == LOCK_BYTE_ADDR ||
                        fw_allowed(code_rd_addr, exec_addr, lock_byte, 1'b0)); // [RULE_20] [RULE_21]
    assign cpu_stall  = seq == SEQ_BUSY;                                  // [RULE_23]
    assign flash_busy = seq == SEQ_BUSY;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped;

    // control registers; reserved bits are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            psc <= PSC_RESET;
            pfe <= PFE_RESET;
        end else if (apb_wr && paddr == PSC_OFFSET) begin
            psc <= pwdata[1:0];                                           // [RULE_06]
        end else if (apb_wr && paddr == PFE_OFFSET) begin
            pfe <= pwdata[TBW_BIT];
        end
    end

    // key lock; dead sticks until reset, an accepted or faulted flash write relocks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            key <= KEY_IDLE;
        end else if (key == KEY_DEAD) begin
            key <= KEY_DEAD;                                              // [RULE_03]
        end else if (fl_wr && key != KEY_OPEN) begin
            key <= KEY_DEAD;                                              // [RULE_04]
        end else if (key_wr) begin
            case (key)
                KEY_IDLE: begin
                    key <= (pwdata[7:0] == KEY_FIRST_CODE) ? KEY_FIRST : KEY_DEAD; // [RULE_01]
                end
                KEY_FIRST: begin
                    key <= (pwdata[7:0] == KEY_SECOND_CODE) ? KEY_OPEN : KEY_DEAD; // [RULE_02]
                end
                default: begin
                    key <= KEY_DEAD;                                      // [RULE_03]
                end
            endcase
        end else if (fw_go || fw_fault) begin
            key <= KEY_IDLE;                                              // [RULE_05] [RULE_14]
        end
    end

    // even half of a pair waits for its odd partner
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pair_pend <= 1'b0;
            pair_addr <= 16'h0000;
            pair_even <= 8'hFF;
        end else if (even_hold) begin
            pair_pend <= 1'b1;
            pair_addr <= move_wr_req.addr;
            pair_even <= new_byte;
        end else if (fw_go || fw_fault) begin
            pair_pend <= 1'b0;
        end
    end

    // sequencer: hardware times each operation while the cpu stalls
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq <= SEQ_IDLE;
            cnt <= 32'h0000_0000;
        end else begin
            case (seq)
                SEQ_IDLE: begin
                    if (fw_start || dbg_start) begin
                        seq <= SEQ_BUSY;
                        if ((fw_start && fl_erase) || (!fw_start && dbg_cmd != DBG_WRITE)) begin
                            cnt <= ERASE_CYC;                             // [RULE_08]
                        end else begin
                            cnt <= PROG_CYC;                              // [RULE_12]
                        end
                    end
                end
                SEQ_BUSY: begin
                    cnt <= cnt - 32'h0000_0001;                           // [RULE_23]
                    if (op_done) begin
                        seq <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq <= SEQ_IDLE;
                end
            endcase
        end
    end

    // array command; a single byte pairs with 0xFF which leaves flash alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_start <= 1'b0;
            flash_cmd   <= '0;
        end else begin
            flash_start <= fw_start || dbg_start;
            if (fw_start && fl_erase) begin
                flash_cmd.op   <= OP_ERASE;                               // [RULE_08]
                flash_cmd.addr <= {move_wr_req.addr[15:9], 9'h000};
                flash_cmd.data <= {ERASED_BYTE, ERASED_BYTE};
            end else if (fw_start) begin
                flash_cmd.op   <= OP_PROGRAM;
                flash_cmd.addr <= {move_wr_req.addr[15:1], 1'b0};
                if (!pfe) begin
                    flash_cmd.data <= move_wr_req.addr[0] ?                // [RULE_10]
                        {new_byte, ERASED_BYTE} : {ERASED_BYTE, new_byte};
                end else if (pair_pend && pair_addr[15:1] == move_wr_req.addr[15:1]) begin
                    flash_cmd.data <= {new_byte, pair_even};              // [RULE_11]
                end else begin
                    flash_cmd.data <= {new_byte, ERASED_BYTE};
                end
            end else if (dbg_start) begin
                flash_cmd.op   <= (dbg_cmd == DBG_CHIP) ? OP_CHIP :
                                  (dbg_cmd == DBG_ERASE) ? OP_ERASE : OP_PROGRAM;
                flash_cmd.addr <= (dbg_cmd == DBG_WRITE) ? {dbg_addr[15:1], 1'b0} :
                                  (dbg_cmd == DBG_CHIP) ? 16'h0000 : {dbg_addr[15:9], 9'h000};
                flash_cmd.data <= dbg_addr[0] ? {dbg_old & dbg_wdata, ERASED_BYTE} :
                                                {ERASED_BYTE, dbg_old & dbg_wdata};
            end
        end
    end

    // error reset request and debug answers, one-cycle pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_error_reset <= 1'b0;
            dbg_done          <= 1'b0;
            dbg_refused       <= 1'b0;
        end else begin
            flash_error_reset <= fw_fault || (code_rd && !code_rd_ok);    // [RULE_22]
            dbg_done          <= dbg_take && !dbg_deny;
            dbg_refused       <= dbg_take && dbg_deny;                    // [RULE_18]
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                PSC_OFFSET:  prdata <= {30'h0, psc};
                KEY_OFFSET:  prdata <= {30'h0, key == KEY_DEAD || key == KEY_OPEN,
                                        key == KEY_DEAD || key == KEY_FIRST};
                PFE_OFFSET:  prdata <= {31'h0, pfe};
                STAT_OFFSET: prdata <= {16'h0, lock_byte, 5'h0, pair_pend,
                                        key == KEY_DEAD, seq == SEQ_BUSY};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    a_key_dead_sticks: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        key == KEY_DEAD |=> key == KEY_DEAD)
        else $error("key lock left the dead state");

    a_early_op_kills: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        (fl_wr && key != KEY_OPEN) |=> key == KEY_DEAD && !flash_start)
        else $error("flash operation before unlock did not lock");

    a_key_pair_opens: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (key_wr && key == KEY_FIRST && pwdata[7:0] == KEY_SECOND_CODE && !fl_wr)
        |=> key == KEY_OPEN)
        else $error("second key code did not open the lock");

    a_relock_after_op: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        (fw_go && !key_wr) |=> key == KEY_IDLE)
        else $error("key stayed open after an operation");

    a_stall_program: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_23]
        (fw_start && !fl_erase) |=> cpu_stall [*8])
        else $error("cpu not stalled during program");

    a_erase_page: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
        (fw_start && fl_erase) |=> flash_cmd.op == OP_ERASE && flash_cmd.addr[8:0] == 9'h000)
        else $error("erase did not target the whole page");

    a_fault_resets: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_22]
        fw_fault |=> flash_error_reset && !flash_start)
        else $error("forbidden firmware access did not reset");

    a_lock_pg_erase: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_20]
        (flash_start && $past(fw_start) && flash_cmd.op == OP_ERASE)
        |-> flash_cmd.addr[15:9] != LOCK_PAGE)
        else $error("firmware erased the lock byte page");

    a_even_no_prog: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
        even_hold |=> !flash_start && pair_pend)
        else $error("even byte of a pair started programming");

    a_read_to_external_ram_space: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_15]
        move_rd |-> external_ram_space_rd)
        else $error("data-move read not sent to external ram");

    a_dbg_locked: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_18]
        (dbg_take && dbg_cmd == DBG_ERASE && page_locked(dbg_addr, lock_byte))
        |=> dbg_refused && !flash_start)
        else $error("debug erase of a locked page was accepted");

endmodule : flash_program_guard
`default_nettype wire

//--- flash_guard_pkg.sv
// constants, field layouts and carrier types for the flash program guard
// assumes a 200 MHz system clock and a 64 kB flash with 512-byte pages
// Functional notes
// RULE_01: two key codes in order open one operation
// RULE_02: any delay between the key codes is accepted
// RULE_03: wrong or misordered key locks until reset
// RULE_04: operation before unlock locks until reset
// RULE_05: each finished operation relocks the key
// RULE_06: write enable steers data-move writes to flash
// RULE_07: byte program only clears bits to zero
// RULE_08: erase sets whole 512-byte page to 0xFF
// RULE_09: write needs write enable, erase needs both
// RULE_10: single-byte mode programs on every write
// RULE_11: pair mode programs after odd after even
// RULE_12: pair program time equals single-byte time
// RULE_13: software writes even then odd, 0xFF keeps
// RULE_14: software unlocks before each byte of pair
// RULE_15: data-move reads always go to external RAM
// RULE_16: complement of lock byte gives locked pages
// RULE_17: lock byte page locked when any page is
// RULE_18: debug port refused on locked pages
// RULE_19: lock byte never gains locked pages, reads free
// RULE_20: unlocked code denied locked pages, lock page
// RULE_21: locked code reaches all but lock page erase
// RULE_22: reserved or forbidden firmware access resets
// RULE_23: cpu stalled while hardware times operation
package flash_guard_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] PSC_OFFSET   = 8'h00;  // program_store_control
    localparam logic [7:0] KEY_OFFSET   = 8'h04;  // flash_unlock_key_reg
    localparam logic [7:0] PFE_OFFSET   = 8'h08;  // prefetch_engine_control
    localparam logic [7:0] STAT_OFFSET  = 8'h0C;  // guard status
    // field positions
    localparam int SWE_BIT     = 0;               // store_write_enable
    localparam int SEE_BIT     = 1;               // store_erase_enable
    localparam int TBW_BIT     = 0;               // two_byte_write_select
    localparam logic [1:0] PSC_RESET = 2'h0;
    localparam logic       PFE_RESET = 1'b0;
    // key codes
    localparam logic [7:0] KEY_FIRST_CODE  = 8'hA5;
    localparam logic [7:0] KEY_SECOND_CODE = 8'hF1;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    // flash geometry
    localparam int ADDR_W    = 16;
    localparam int PAGE_LSB  = 9;                 // 512-byte pages
    localparam logic [15:0] LOCK_BYTE_ADDR = 16'hFBFF;
    localparam logic [6:0]  LOCK_PAGE = LOCK_BYTE_ADDR[15:9];
    // timing
    localparam int CLK_MHZ        = 200;
    localparam int PROG_TIME_NS   = 20000;        // least byte/pair program time
    localparam int PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_TIME_NS  = 10000000;     // least page erase time
    localparam int ERASE_CYCLES   = (ERASE_TIME_NS / 1000) * CLK_MHZ;

    typedef enum logic [3:0] {
        KEY_IDLE  = 4'b0001,
        KEY_FIRST = 4'b0010,
        KEY_OPEN  = 4'b0100,
        KEY_DEAD  = 4'b1000
    } key_state_t;

    typedef enum logic [1:0] {
        OP_PROGRAM = 2'h0,
        OP_ERASE   = 2'h1,
        OP_CHIP    = 2'h2
    } flash_op_t;

    typedef enum logic [1:0] {
        DBG_READ  = 2'h0,
        DBG_WRITE = 2'h1,
        DBG_ERASE = 2'h2,
        DBG_CHIP  = 2'h3
    } dbg_cmd_t;

    // one flash array command
    typedef struct packed {
        flash_op_t   op;
        logic [15:0] addr;    // pair aligned for program
        logic [15:0] data;    // {odd, even} bytes
    } flash_cmd_t;

    // one cpu data-move write
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } move_wr_t;
endpackage : flash_guard_pkg

//--- flash_array_model.sv
// flash array model: byte store that carries out started commands
// assumes the guard holds flash_cmd steady after its one-cycle start
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    input  wire logic                        clk,
    input  wire logic                        flash_start,
    input  wire flash_guard_pkg::flash_cmd_t flash_cmd,
    input  wire logic [15:0]                 rd_addr,
    output logic [15:0]                      flash_rd_pair,
    output logic [7:0]                       lock_byte
);
    import flash_guard_pkg::*;
    logic [7:0]  mem [0:65535];
    logic [15:0] ev;
    // combinational pair read, as a real array answers within the cycle
    assign ev            = {rd_addr[15:1], 1'b0};
    assign flash_rd_pair = {mem[ev | 16'h1], mem[ev]};
    assign lock_byte     = mem[LOCK_BYTE_ADDR];
    initial begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
    end
    // cells only lose ones when programmed, so the model ands as well
    always @(posedge clk) begin
        if (flash_start && flash_cmd.op == OP_PROGRAM) begin
            mem[flash_cmd.addr] <= mem[flash_cmd.addr] & flash_cmd.data[7:0];
            mem[flash_cmd.addr | 16'h1] <= mem[flash_cmd.addr | 16'h1] & flash_cmd.data[15:8];
        end else if (flash_start && flash_cmd.op == OP_ERASE) begin
            for (int i = 0; i < 512; i++) mem[{flash_cmd.addr[15:9], i[8:0]}] <= 8'hFF;
        end else if (flash_start && flash_cmd.op == OP_CHIP) begin
            foreach (mem[i]) mem[i] <= 8'hFF;
        end
    end
endmodule : flash_array_model
`default_nettype wire

//--- flash_program_guard_tb_top.sv
// testbench for the flash program guard: apb, cpu and debug stimulus
// assumes the array model beside it and shortened operation times
`timescale 1ns/1ps
`default_nettype none
module flash_program_guard_tb_top;
    import flash_guard_pkg::*;
    localparam int PROG_N  = 10;
    localparam int ERASE_N = 20;
    logic clk, rst_b, psel, penable, pwrite, move_wr, move_rd, code_rd, dbg_req;
    logic pready, pslverr, external_ram_space_wr, external_ram_space_rd, code_rd_ok, cpu_stall, flash_busy;
    logic flash_error_reset, dbg_done, dbg_refused, flash_start, serr, st, er, xw, dn, rf;
    logic [7:0]  paddr, dbg_wdata, lock_byte, d, d2;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] exec_addr, code_rd_addr, dbg_addr, flash_rd_pair, a;
    move_wr_t    move_wr_req;
    dbg_cmd_t    dbg_cmd;
    flash_cmd_t  flash_cmd;
    int          ns, num_errors, checks_done;

    flash_program_guard #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) i_dut (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .move_wr, .move_wr_req, .move_rd, .exec_addr, .code_rd, .code_rd_addr,
        .external_ram_space_wr, .external_ram_space_rd, .code_rd_ok, .cpu_stall, .flash_error_reset, .dbg_req,
        .dbg_cmd, .dbg_addr, .dbg_wdata, .dbg_done, .dbg_refused, .lock_byte,
        .flash_rd_pair, .flash_start, .flash_cmd, .flash_busy);
    flash_array_model i_flash (.clk, .flash_start, .flash_cmd, .flash_rd_pair, .lock_byte,
        .rd_addr(dbg_req ? dbg_addr : move_wr_req.addr));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic hang();
        num_errors++;
        stop_test();
    endtask : hang

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // expected program word: the untouched partner byte stays erased
    function automatic logic [15:0] pad(input logic [15:0] ad, input logic [7:0] wd);
        return ad[0] ? {wd, ERASED_BYTE} : {ERASED_BYTE, wd};
    endfunction : pad

    // counts stalled cycles; bounded so a stuck stall ends the run
    task automatic wait_stall();
        ns = 0;
        while (cpu_stall === 1'b1 && ns < 100) begin
            @(posedge clk);
            #1;
            ns++;
        end
        if (ns >= 100) hang();
    endtask : wait_stall

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) hang();
    endtask : apb

    task automatic unlock();
        apb(1'b1, KEY_OFFSET, {24'h0, KEY_FIRST_CODE});
        repeat ($urandom_range(40, 0)) @(posedge clk);
        apb(1'b1, KEY_OFFSET, {24'h0, KEY_SECOND_CODE});
    endtask : unlock

    task automatic mwr(input logic [15:0] ad, input logic [7:0] wd);
        @(posedge clk);
        move_wr     <= 1'b1;
        move_wr_req <= '{ad, wd};
        @(posedge clk);
        xw = external_ram_space_wr;
        move_wr <= 1'b0;
        #1;
        st = flash_start;
        er = flash_error_reset;
        wait_stall();
    endtask : mwr

    task automatic dbg(input dbg_cmd_t c, input logic [15:0] ad, input logic [7:0] wd);
        @(posedge clk);
        dbg_req   <= 1'b1;
        dbg_cmd   <= c;
        dbg_addr  <= ad;
        dbg_wdata <= wd;
        @(posedge clk);
        dbg_req <= 1'b0;
        #1;
        dn = dbg_done;
        rf = dbg_refused;
        wait_stall();
    endtask : dbg

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    initial begin
        {psel, penable, pwrite, move_wr, move_rd, code_rd, dbg_req} = '0;
        {paddr, pwdata, dbg_wdata, exec_addr, code_rd_addr, dbg_addr} = '0;
        move_wr_req = '0;
        dbg_cmd     = DBG_READ;
        rst_b       = 1'b0;
        num_errors  = 0;
        checks_done = 0;
        void'($urandom(32'h6902FDF9));
        do_reset();
        // reset values, unmapped word, write enable still clear
        apb(1'b0, PSC_OFFSET, '0);
        chk("psc reset", PSC_RESET, rdat);
        apb(1'b0, 8'h40, '0);
        chk("unmapped err", 1, serr);
        mwr(16'h0200, 8'h00);
        chk("external_ram_space write", 1, xw);
        chk("no start", 0, st);
        // random single-byte programs on erased cells
        apb(1'b1, PSC_OFFSET, 32'h1);
        repeat (4) begin
            a = 16'($urandom_range(16'hF9FF, 16'h0400));
            d = 8'($urandom);
            unlock();
            mwr(a, d);
            chk("prog start", 1, st);
            chk("prog addr", {a[15:1], 1'b0}, flash_cmd.addr);
            chk("prog data", pad(a, d), flash_cmd.data);
            chk("prog time", PROG_N, ns);
            apb(1'b0, KEY_OFFSET, '0);
            chk("key relocked", 0, rdat);
        end
        d2 = 8'($urandom);
        unlock();
        mwr(a, d2);
        chk("reprogram", pad(a, d & d2), flash_cmd.data);
        apb(1'b0, PSC_OFFSET, '0);
        chk("enable held", 1, rdat);
        // pair mode: even byte waits, odd byte programs both
        apb(1'b1, PFE_OFFSET, 32'h1);
        a = 16'($urandom_range(16'h7FFF, 16'h4000)) & 16'hFFFE;
        unlock();
        mwr(a, d2);
        chk("even no start", 0, st);
        unlock();
        mwr(a | 16'h1, d);
        chk("pair data", {d, d2}, flash_cmd.data);
        chk("pair time", PROG_N, ns);
        apb(1'b1, PFE_OFFSET, 32'h0);
        // page erase with both enables set
        apb(1'b1, PSC_OFFSET, 32'h3);
        unlock();
        mwr(a | 16'h1, 8'($urandom));
        chk("erase op", OP_ERASE, flash_cmd.op);
        chk("erase time", ERASE_N, ns);
        chk("page blank", 8'hFF, i_flash.mem[a]);
        // a wrong key, or a write before unlocking, closes the key
        apb(1'b1, KEY_OFFSET, 32'h5A);
        unlock();
        mwr(a, 8'h00);
        chk("dead no start", 0, st);
        do_reset();
        apb(1'b1, PSC_OFFSET, 32'h1);
        mwr(a, 8'h00);
        unlock();
        mwr(a, 8'h00);
        chk("early write", 0, st);
        do_reset();
        // lock byte FD: pages 0 and 1 plus the lock byte page
        i_flash.mem[LOCK_BYTE_ADDR] = 8'hFD;
        apb(1'b1, PSC_OFFSET, 32'h1);
        exec_addr <= 16'h2000;
        unlock();
        mwr(16'h0400, 8'h0F);
        chk("first free page", 1, st);
        unlock();
        mwr(16'h0300, 8'h00);
        chk("locked from free", 1, er);
        unlock();
        mwr(16'hFA10, 8'h00);
        chk("lock page locked", 1, er);
        exec_addr <= 16'h0010;
        unlock();
        mwr(16'h0300, 8'hAA);
        chk("locked from locked", 1, st);
        apb(1'b1, PSC_OFFSET, 32'h3);
        unlock();
        mwr(16'hFA00, 8'h00);
        chk("lock page erase", 1, er);
        // debug port access to locked space
        dbg(DBG_READ, 16'h0000, 8'h00);
        chk("dbg locked", 1, rf);
        dbg(DBG_READ, LOCK_BYTE_ADDR, 8'h00);
        chk("dbg lock read", 1, dn);
        dbg(DBG_WRITE, LOCK_BYTE_ADDR, 8'hFC);
        chk("dbg lock more", 1, rf);
        dbg(DBG_CHIP, 16'h0000, 8'h00);
        chk("device erase", OP_CHIP, flash_cmd.op);
        chk("lock cleared", 8'hFF, lock_byte);
        @(posedge clk);
        move_rd <= 1'b1;
        @(posedge clk);
        chk("external_ram_space read", 1, external_ram_space_rd);
        move_rd <= 1'b0;
        stop_test();
    end
endmodule : flash_program_guard_tb_top
`default_nettype wire
